//--- logic/ddp_core.sv
// How it works
// - ODT registered high switches termination on
// - x4/x8 terminate DQ, DQS pair, DM; x8 with read strobe on terminates RDQS pair instead of DM
// - x16 terminates all DQ, both strobe pairs, masks
// - Termination disabled in EMR ignores ODT
// - CS, RAS, CAS, WE decode each command
// - Write beat with mask high is discarded unless the x8 read strobe is on
// - Mask sampled on both write strobe edges
// - x8 EMR bit turns mask into read strobe
// - Bank bits pick bank; only two used
// - Bank bits pick mode register on MRS
// - Address carries row, then column plus auto-precharge
// - Precharge A10 low one bank, high all
// - Single precharge closes bank from bank bits
// - MRS stores address as op-code
// - Device drives strobe with read data only
// - Read strobe edges align with data changes
// - Lower strobe times DQ0-7, upper DQ8-15
// - One EMR bit, when set, disables all complement strobes
// - Chip select high ignores the command
`timescale 1ns/1ps
`include "ddp_defines.svh"

module ddp_core
  import ddp_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  ddp_org_e         org_i,
  input  ddp_cmd_s         cmd_i,
  input  wire logic        odt_i,
  input  wire logic        ldqs_clk_i,
  input  wire logic        udqs_clk_i,
  input  wire logic [15:0] dq_i,
  input  wire logic [1:0]  dm_i,
  output logic [15:0]      dq_o,
  output logic             dq_oe_n_o,
  output logic [1:0]       dqs_o,
  output logic             dqs_oe_n_o,
  output logic [1:0]       dqs_n_o,
  output logic             dqs_n_oe_n_o,
  output logic             rdqs_o,
  output logic             rdqs_n_o,
  output logic             rdqs_oe_n_o,
  output logic             rdqs_n_oe_n_o,
  output ddp_term_s        term_o,
  output logic [3:0]       bank_open_o,
  output logic [15:0]      mode_reg_o,
  output logic [15:0]      ext_mode_o
);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  function automatic ddp_cmd_e cmd_decode(input ddp_cmd_s c);
    ddp_cmd_e r;
    if (c.cs_n) begin
      r = DDP_CMD_DESEL;
    end else begin
      case ({c.ras_n, c.cas_n, c.we_n})
        3'h7:    r = DDP_CMD_NOP;
        3'h3:    r = DDP_CMD_ACT;
        3'h5:    r = DDP_CMD_RD;
        3'h4:    r = DDP_CMD_WR;
        3'h2:    r = DDP_CMD_PRE;
        3'h1:    r = DDP_CMD_REF;
        3'h0:    r = DDP_CMD_MRS;
        default: r = DDP_CMD_NOP;
      endcase
    end
    return r;
  endfunction

  ddp_cmd_e   cmd;
  logic [1:0] bank;
  logic       rtt_on;
  logic       dqsn_on;
  logic       rdqs_on;
  ddp_org_e   org;

  assign cmd     = cmd_decode(cmd_i);
  assign bank    = cmd_i.ba[1:0];
  assign rtt_on  = ext_mode_o[`DDP_RTT0_POS] | ext_mode_o[`DDP_RTT1_POS];
  assign dqsn_on = ~ext_mode_o[`DDP_DQSN_DIS_POS];
  assign rdqs_on = (org == DDP_ORG_X8) & ext_mode_o[`DDP_RDQS_EN_POS];

  // ----------------------------------------------------------------
  // Organisation strap, caught while reset is held
  // ----------------------------------------------------------------
  // Only a reset reloads the strap, so it stands still in operation

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      org <= org_i;
    end
  end

  // ----------------------------------------------------------------
  // Mode registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mode_reg_o <= `DDP_MR_RST;
      ext_mode_o <= `DDP_EMR_RST;
    end else if (cmd == DDP_CMD_MRS) begin
      if (cmd_i.ba[1:0] == `DDP_MR_SEL) begin
        mode_reg_o <= cmd_i.addr;
      end else if (cmd_i.ba[1:0] == `DDP_EMR1_SEL) begin
        ext_mode_o <= cmd_i.addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bank open state
  // ----------------------------------------------------------------
  logic       auto_pre;

  assign auto_pre = cmd_i.addr[`DDP_A10_POS];

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      bank_open_o <= 4'h0;
    end else begin
      case (cmd)
        DDP_CMD_ACT: begin
          bank_open_o[bank] <= 1'h1;
        end
        DDP_CMD_PRE: begin
          if (cmd_i.addr[`DDP_A10_POS]) begin
            bank_open_o <= 4'h0;
          end else begin
            bank_open_o[bank] <= 1'h0;
          end
        end
        DDP_CMD_RD, DDP_CMD_WR: begin
          if (auto_pre) begin
            bank_open_o[bank] <= 1'h0;
          end
        end
        default: begin
          bank_open_o <= bank_open_o;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // On-die termination
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      term_o <= '0;
    end else if (!odt_i || !rtt_on) begin
      term_o <= '0;
    end else begin
      case (org)
        DDP_ORG_X16: begin
          term_o.dq     <= 16'hFFFF;
          term_o.strb   <= 2'h3;
          term_o.strb_n <= 2'h3;
          term_o.dm     <= 2'h3;
        end
        DDP_ORG_X8: begin
          term_o.dq     <= 16'h00FF;
          term_o.strb   <= {rdqs_on, 1'h1};
          term_o.strb_n <= {rdqs_on, 1'h1};
          term_o.dm     <= {1'h0, ~rdqs_on};
        end
        default: begin
          term_o.dq     <= 16'h000F;
          term_o.strb   <= 2'h1;
          term_o.strb_n <= 2'h1;
          term_o.dm     <= 2'h1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Write capture, one strobe domain per byte lane
  // ----------------------------------------------------------------
  ddp_burst_s burst [2];
  logic [1:0] done_tgl;
  logic [1:0] tgl_s1;
  logic [1:0] tgl_s2;
  logic [1:0] tgl_s3;
  logic [1:0] lane_done;

  ddp_wcap u_wcap_lo (
    .stb_clk_i  (ldqs_clk_i),
    .rst_n_i    (rst_n_i),
    .dq_i       (dq_i[7:0]),
    .dm_i       (dm_i[0]),
    .burst_o    (burst[0]),
    .done_tgl_o (done_tgl[0])
  );

  ddp_wcap u_wcap_hi (
    .stb_clk_i  (udqs_clk_i),
    .rst_n_i    (rst_n_i),
    .dq_i       (dq_i[15:8]),
    .dm_i       (dm_i[1]),
    .burst_o    (burst[1]),
    .done_tgl_o (done_tgl[1])
  );

  // Burst-done toggles cross into the command clock
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tgl_s1 <= 2'h0;
      tgl_s2 <= 2'h0;
      tgl_s3 <= 2'h0;
    end else begin
      tgl_s1 <= done_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  assign lane_done = tgl_s2 ^ tgl_s3;

  // ----------------------------------------------------------------
  // Data store and write commit
  // ----------------------------------------------------------------
  logic [15:0] mem [`DDP_MEM_DEPTH];
  logic [1:0]  wr_blk;

  // Column block latched with the write command
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      wr_blk <= 2'h0;
    end else if (cmd == DDP_CMD_WR) begin
      wr_blk <= cmd_i.addr[3:2];
    end
  end

  // Masked beats leave the stored byte unchanged unless the x8 read strobe is enabled
  always_ff @(posedge mclk_i) begin
    for (int l = 0; l < 2; l++) begin
      for (int b = 0; b < 4; b++) begin
        if (lane_done[l] && (!burst[l].mask[b] || rdqs_on)) begin
          mem[{wr_blk, 2'(b)}][l*8 +: 8] <= burst[l].data[b*8 +: 8];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read burst sequencer
  // ----------------------------------------------------------------
  ddp_rd_e    rd_st;
  logic [2:0] rd_cnt;
  logic [1:0] rd_blk;
  logic [1:0] rd_beat;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rd_st   <= DDP_RD_IDLE;
      rd_cnt  <= 3'h0;
      rd_blk  <= 2'h0;
      rd_beat <= 2'h0;
    end else begin
      case (rd_st)
        DDP_RD_IDLE: begin
          if (cmd == DDP_CMD_RD) begin
            rd_st  <= DDP_RD_WAIT;
            rd_cnt <= `DDP_RD_LAT;
            rd_blk <= cmd_i.addr[3:2];
          end
        end
        DDP_RD_WAIT: begin
          rd_cnt <= rd_cnt - 3'h1;
          if (rd_cnt == 3'h1) begin
            rd_st   <= DDP_RD_BURST;
            rd_beat <= 2'h0;
          end
        end
        DDP_RD_BURST: begin
          rd_beat <= rd_beat + 2'h1;
          if (rd_beat == 2'h3) begin
            rd_st <= DDP_RD_IDLE;
          end
        end
        default: begin
          rd_st <= DDP_RD_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read pin drivers
  // ----------------------------------------------------------------
  logic drive;
  logic next_dqs;

  assign drive    = (rd_st == DDP_RD_WAIT && rd_cnt == 3'h1) || (rd_st == DDP_RD_BURST
                    && rd_beat != 2'h3);
  assign next_dqs = (rd_st == DDP_RD_WAIT) ? 1'h1 : rd_beat[0];

  // Each new beat comes with a strobe edge
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || !drive) begin
      dq_o          <= 16'h0000;
      dq_oe_n_o     <= 1'h1;
      dqs_o         <= 2'h0;
      dqs_oe_n_o    <= 1'h1;
      dqs_n_o       <= 2'h3;
      dqs_n_oe_n_o  <= 1'h1;
      rdqs_o        <= 1'h0;
      rdqs_n_o      <= 1'h1;
      rdqs_oe_n_o   <= 1'h1;
      rdqs_n_oe_n_o <= 1'h1;
    end else begin
      dq_o          <= mem[{rd_blk, (rd_st == DDP_RD_WAIT) ? 2'h0 : rd_beat + 2'h1}];
      dq_oe_n_o     <= 1'h0;
      dqs_o         <= {2{next_dqs}};
      dqs_oe_n_o    <= 1'h0;
      dqs_n_o       <= {2{~next_dqs}};
      dqs_n_oe_n_o  <= ~dqsn_on;
      rdqs_o        <= next_dqs;
      rdqs_n_o      <= ~next_dqs;
      rdqs_oe_n_o   <= ~rdqs_on;
      rdqs_n_oe_n_o <= ~(rdqs_on & dqsn_on);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_cs_mask;
    @(posedge mclk_i) disable iff (!rst_n_i)
    cmd_i.cs_n |=> $stable(bank_open_o) && $stable(mode_reg_o);
  endproperty
  a_cs_mask: assert property (p_cs_mask) else $error("deselected cmd acted");

  property p_act;
    @(posedge mclk_i) disable iff (!rst_n_i)
    cmd == DDP_CMD_ACT |=> bank_open_o[$past(bank)];
  endproperty
  a_act: assert property (p_act) else $error("activate did not open bank");

  property p_pre_all;
    @(posedge mclk_i) disable iff (!rst_n_i)
    cmd == DDP_CMD_PRE && cmd_i.addr[`DDP_A10_POS] |=> bank_open_o == 4'h0;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("all-bank precharge failed");

  property p_pre_one;
    @(posedge mclk_i) disable iff (!rst_n_i)
    cmd == DDP_CMD_PRE && !cmd_i.addr[`DDP_A10_POS] |=>
      bank_open_o == ($past(bank_open_o) & ~(4'h1 << $past(bank)));
  endproperty
  a_pre_one: assert property (p_pre_one) else $error("single precharge wrong bank");

  property p_mrs;
    @(posedge mclk_i) disable iff (!rst_n_i)
    cmd == DDP_CMD_MRS && cmd_i.ba[1:0] == `DDP_MR_SEL |=>
      mode_reg_o == $past(cmd_i.addr) && $stable(ext_mode_o);
  endproperty
  a_mrs: assert property (p_mrs) else $error("mode register not loaded");

  property p_odt_off;
    @(posedge mclk_i) disable iff (!rst_n_i)
    !rtt_on |=> term_o == '0;
  endproperty
  a_odt_off: assert property (p_odt_off) else $error("termination with rtt off");

  property p_odt_x16;
    @(posedge mclk_i) disable iff (!rst_n_i)
    odt_i && rtt_on && org == DDP_ORG_X16 |=> term_o.dq == 16'hFFFF && term_o.dm == 2'h3;
  endproperty
  a_odt_x16: assert property (p_odt_x16) else $error("x16 termination missing");

  property p_rd_drive;
    @(posedge mclk_i) disable iff (!rst_n_i)
    cmd == DDP_CMD_RD && rd_st == DDP_RD_IDLE |=>
      dq_oe_n_o[*3] ##1 (!dq_oe_n_o && !dqs_oe_n_o)[*4] ##1 dq_oe_n_o;
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("read burst window wrong");

  property p_rd_edge;
    @(posedge mclk_i) disable iff (!rst_n_i)
    !dq_oe_n_o && $past(!dq_oe_n_o) |-> dqs_o[0] != $past(dqs_o[0]);
  endproperty
  a_rd_edge: assert property (p_rd_edge) else $error("strobe missed a beat");

  property p_dqsn;
    @(posedge mclk_i) disable iff (!rst_n_i)
    ext_mode_o[`DDP_DQSN_DIS_POS] && !dq_oe_n_o |-> dqs_n_oe_n_o && rdqs_n_oe_n_o;
  endproperty
  a_dqsn: assert property (p_dqsn) else $error("complement strobe driven");

endmodule

//--- logic/ddp_defines.svh
`ifndef DDP_DEFINES_SVH
`define DDP_DEFINES_SVH

// ----------------------------------------------------------------
// Pin widths
// ----------------------------------------------------------------
`define DDP_ADDR_W      16
`define DDP_BA_W        3
`define DDP_DQ_W        16
`define DDP_LANE_W      8
`define DDP_BANKS       4

// ----------------------------------------------------------------
// Address and bank fields
// ----------------------------------------------------------------
`define DDP_A10_POS     4'hA
`define DDP_MR_SEL      2'h0
`define DDP_EMR1_SEL    2'h1
`define DDP_EMR2_SEL    2'h2
`define DDP_EMR3_SEL    2'h3

// ----------------------------------------------------------------
// Extended mode register 1 fields
// ----------------------------------------------------------------
`define DDP_RTT0_POS    4'h2
`define DDP_RTT1_POS    4'h6
`define DDP_DQSN_DIS_POS 4'hA
`define DDP_RDQS_EN_POS 4'hB

// ----------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------
`define DDP_MR_RST      16'h0000
`define DDP_EMR_RST     16'h0000
`define DDP_BURST_LEN   3'h4
`define DDP_RD_LAT      3'h3
`define DDP_MEM_DEPTH   16

`endif

//--- logic/ddp_pkg.sv
package ddp_pkg;

  typedef enum logic [2:0] {
    DDP_CMD_DESEL = 3'h0,
    DDP_CMD_NOP   = 3'h1,
    DDP_CMD_ACT   = 3'h2,
    DDP_CMD_RD    = 3'h3,
    DDP_CMD_WR    = 3'h4,
    DDP_CMD_PRE   = 3'h5,
    DDP_CMD_REF   = 3'h6,
    DDP_CMD_MRS   = 3'h7
  } ddp_cmd_e;

  typedef enum logic [1:0] {
    DDP_ORG_X4  = 2'h0,
    DDP_ORG_X8  = 2'h1,
    DDP_ORG_X16 = 2'h2
  } ddp_org_e;

  typedef enum logic [1:0] {
    DDP_RD_IDLE  = 2'h0,
    DDP_RD_WAIT  = 2'h1,
    DDP_RD_BURST = 2'h2
  } ddp_rd_e;

  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  ba;
    logic [15:0] addr;
  } ddp_cmd_s;

  typedef struct packed {
    logic [15:0] dq;
    logic [1:0]  strb;
    logic [1:0]  strb_n;
    logic [1:0]  dm;
  } ddp_term_s;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0]  mask;
  } ddp_burst_s;

endpackage

//--- logic/ddp_wcap.sv
`timescale 1ns/1ps
`include "ddp_defines.svh"

module ddp_wcap
  import ddp_pkg::*;
(
  input  wire logic       stb_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [7:0] dq_i,
  input  wire logic       dm_i,
  output ddp_burst_s      burst_o,
  output logic            done_tgl_o
);

  // ----------------------------------------------------------------
  // Beat capture on both strobe edges
  // ----------------------------------------------------------------
  logic [7:0] rise_dq;
  logic       rise_dm;
  logic       pair_idx;

  // Rising edge holds the even beat and its mask
  always_ff @(posedge stb_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rise_dq <= 8'h00;
      rise_dm <= 1'h0;
    end else begin
      rise_dq <= dq_i;
      rise_dm <= dm_i;
    end
  end

  // Falling edge completes a beat pair; strobe stops between bursts,
  // so the held burst stays still until the next burst starts
  always_ff @(negedge stb_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      burst_o    <= '0;
      pair_idx   <= 1'h0;
      done_tgl_o <= 1'h0;
    end else begin
      pair_idx <= ~pair_idx;
      if (pair_idx) begin
        burst_o.data[31:16] <= {dq_i, rise_dq};
        burst_o.mask[3:2]   <= {dm_i, rise_dm};
        done_tgl_o          <= ~done_tgl_o;
      end else begin
        burst_o.data[15:0] <= {dq_i, rise_dq};
        burst_o.mask[1:0]  <= {dm_i, rise_dm};
      end
    end
  end

endmodule

//--- sim/ddp_ctl_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Controller write side: strobe, data and mask
// ----------------------------------------------------------------
module ddp_ctl_model (
  output logic [1:0]  dqs_o,
  output logic [15:0] dq_o,
  output logic [1:0]  dm_o
);
  // Strobe stands still low outside bursts
  initial begin
    dqs_o = 2'h0;
    dq_o  = 16'h0000;
    dm_o  = 2'h0;
  end

  // Four beats; each data change sits midway between strobe edges;
  // only the lanes set in ln see strobe edges
  task automatic burst(input logic [63:0] d, input logic [7:0] m, input logic [1:0] ln);
    #3.3;
    for (int i = 0; i < 4; i++) begin
      dq_o = d[16*i +: 16];
      dm_o = m[2*i +: 2];
      #3.75;
      dqs_o = dqs_o ^ ln;
      #3.75;
    end
    // Released lines show no stale value
    dq_o = ~dq_o;
    dm_o = ~dm_o;
  endtask
endmodule

//--- sim/ddr2_sdram_pin_interface_test.sv
`timescale 1ns/1ps

module ddr2_sdram_pin_interface_test
  import ddp_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and reference state
  // ----------------------------------------------------------------
  localparam logic [3:0] C_NOP = 4'h7;
  localparam logic [3:0] C_ACT = 4'h3;
  localparam logic [3:0] C_RD  = 4'h5;
  localparam logic [3:0] C_WR  = 4'h4;
  localparam logic [3:0] C_PRE = 4'h2;
  localparam logic [3:0] C_MRS = 4'h0;
  logic              mclk_i;
  logic              rst_n_i = 1'b1;
  ddp_org_e          org_i = DDP_ORG_X16;
  ddp_cmd_s          cmd_i;
  logic              odt_i;
  logic [1:0]        dqs;
  logic [15:0]       wdq;
  logic [1:0]        wdm;
  logic [15:0]       dq_o;
  logic              dq_oe_n_o;
  logic [1:0]        dqs_o;
  logic              dqs_oe_n_o;
  logic [1:0]        dqs_n_o;
  logic              dqs_n_oe_n_o;
  logic              rdqs_o;
  logic              rdqs_n_o;
  logic              rdqs_oe_n_o;
  logic              rdqs_n_oe_n_o;
  logic              ro;
  ddp_term_s         term_o;
  logic [3:0]        bank_open_o;
  logic [15:0]       mode_reg_o;
  logic [15:0]       ext_mode_o;
  logic [15:0]       mem [16];
  logic [15:0]       mr;
  logic [15:0]       emr;
  logic [31:0]       r;
  int                err_count;
  int                checks_done;
  logic [22:0]       ops [9] = '{{C_ACT, 3'h5, 16'h0000}, {4'hB, 3'h0, 16'h0000},
    {C_ACT, 3'h0, 16'h0000}, {C_ACT, 3'h2, 16'h0000}, {C_ACT, 3'h3, 16'h0000},
    {C_PRE, 3'h2, 16'hFBFF}, {C_PRE, 3'h1, 16'h0400}, {C_ACT, 3'h6, 16'h0000},
    {C_WR, 3'h2, 16'h0400}};
  logic [3:0]        bexp [9] = '{4'h2, 4'h2, 4'h3, 4'h7, 4'hF, 4'hB, 4'h0, 4'h4, 4'h0};

  // Mask pin works as read strobe on x8 with the enable bit set
  assign ro = (org_i == DDP_ORG_X8) && emr[11];

  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  ddp_core DUT (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .org_i(org_i), .cmd_i(cmd_i), .odt_i(odt_i),
    .ldqs_clk_i(dqs[0]), .udqs_clk_i(dqs[1]), .dq_i(wdq), .dm_i(wdm), .dq_o(dq_o),
    .dq_oe_n_o(dq_oe_n_o), .dqs_o(dqs_o), .dqs_oe_n_o(dqs_oe_n_o), .dqs_n_o(dqs_n_o),
    .dqs_n_oe_n_o(dqs_n_oe_n_o), .rdqs_o(rdqs_o), .rdqs_n_o(rdqs_n_o),
    .rdqs_oe_n_o(rdqs_oe_n_o), .rdqs_n_oe_n_o(rdqs_n_oe_n_o), .term_o(term_o),
    .bank_open_o(bank_open_o),
    .mode_reg_o(mode_reg_o), .ext_mode_o(ext_mode_o));

  ddp_ctl_model ctl (.dqs_o(dqs), .dq_o(wdq), .dm_o(wdm));

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // One command cycle followed by a NOP; clock enable is taken as held high throughout
  task automatic cmd(input logic [3:0] c, input logic [2:0] ba, input logic [15:0] a);
    @(posedge mclk_i);
    cmd_i <= {c, ba, a};
    @(posedge mclk_i);
    cmd_i <= {C_NOP, 19'h00000};
  endtask

  task automatic settle();
    @(posedge mclk_i);
    #1;
  endtask

  // Register outputs right after a reset release
  task automatic rst_chk();
    settle();
    check(mode_reg_o, 16'h0000);
    check(ext_mode_o, 16'h0000);
    check(bank_open_o, 4'h0);
    check(term_o, 22'h000000);
    check(dq_oe_n_o, 1'b1);
  endtask

  // Mid-run reset that loads a new organisation strap
  task automatic restart(input ddp_org_e o);
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    org_i   <= o;
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    mr = 16'h0000;
    emr = 16'h0000;
    rst_chk();
  endtask

  // Write burst on the lanes in ln, reference store updated per unmasked byte, or per byte when ro is set
  task automatic wr(input logic [1:0] blk, input logic [63:0] d, input logic [7:0] m,
                    input logic [1:0] ln);
    cmd(C_WR, 3'h0, {12'h000, blk, 2'h0});
    ctl.burst(d, m, ln);
    repeat (8) @(posedge mclk_i);
    for (int i = 0; i < 4; i++)
      for (int l = 0; l < 2; l++)
        if (ln[l] && (!m[2*i+l] || ro)) mem[{blk, i[1:0]}][8*l +: 8] = d[16*i+8*l +: 8];
    #1 check(dq_oe_n_o, 1'b1);
  endtask

  // Read with a second read on the next cycle, during the latency wait, which must be ignored
  task automatic rd(input logic [1:0] blk, input logic [1:0] blk2);
    @(posedge mclk_i);
    cmd_i <= {C_RD, 3'h0, 12'h000, blk, 2'h0};
    @(posedge mclk_i);
    cmd_i <= {C_RD, 3'h0, 12'h000, blk2, 2'h0};
    @(posedge mclk_i);
    cmd_i <= {C_NOP, 19'h00000};
    repeat (2) @(posedge mclk_i);
    for (int i = 0; i < 4; i++) begin
      #1;
      check(dq_oe_n_o, 1'b0);
      check(dq_o, mem[{blk, i[1:0]}]);
      check(dqs_o, {2{~i[0]}});
      check(dqs_n_oe_n_o, emr[10]);
      check({dqs_oe_n_o, dqs_n_o, rdqs_o, rdqs_n_o}, {1'b0, {2{i[0]}}, ~i[0], i[0]});
      check({rdqs_oe_n_o, rdqs_n_oe_n_o}, {~ro, ~(ro & ~emr[10])});
      @(posedge mclk_i);
    end
    #1 check(dq_oe_n_o, 1'b1);
  endtask

  task automatic odt(input logic v, input logic [31:0] exp);
    @(posedge mclk_i);
    odt_i <= v;
    repeat (2) @(posedge mclk_i);
    #1 check(term_o, exp);
  endtask

  // Watchdog
  initial begin
    repeat (5000) @(posedge mclk_i);
    err_count++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    cmd_i = {C_NOP, 19'h00000};
    odt_i = 1'b0;
    mr = 16'h0000;
    emr = 16'h0000;
    void'($urandom(32'hD6D69DDC));
    // Reset falls after time zero so the strobe-side flops surely see the edge
    #1 rst_n_i = 1'b0;
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rst_chk();
    // Mode register selection by bank bits; bank 2 stores nowhere
    for (int i = 0; i < 3; i++) begin
      r = $urandom();
      cmd(C_MRS, i[2:0], r[15:0]);
      if (i == 0) mr = r[15:0];
      if (i == 1) emr = r[15:0];
      settle();
      check(mode_reg_o, mr);
      check(ext_mode_o, emr);
    end
    // Bank open and precharge table
    for (int i = 0; i < 9; i++) begin
      cmd(ops[i][22:19], ops[i][18:16], ops[i][15:0]);
      settle();
      check(bank_open_o, bexp[i]);
    end
    // Termination on, off by mode register, off by pin
    emr = 16'h0004;
    cmd(C_MRS, 3'h1, emr);
    odt(1'b1, 22'h3FFFFF);
    cmd(C_MRS, 3'h1, 16'h0000);
    odt(1'b1, 22'h000000);
    cmd(C_MRS, 3'h1, emr);
    odt(1'b0, 22'h000000);
    // Writes, a masked overwrite, then reads
    wr(2'h1, {$urandom(), $urandom()}, 8'h00, 2'h3);
    wr(2'h2, {$urandom(), $urandom()}, 8'h00, 2'h3);
    r = $urandom();
    wr(2'h1, {$urandom(), $urandom()}, r[7:0], 2'h3);
    rd(2'h1, 2'h2);
    emr = 16'h0404;
    cmd(C_MRS, 3'h1, emr);
    rd(2'h2, 2'h1);
    // Upper strobe alone writes only the upper byte lane
    wr(2'h2, {$urandom(), $urandom()}, 8'h00, 2'h2);
    rd(2'h2, 2'h0);
    // x8 strap: narrower termination, mask pin as read strobe, masks ignored
    restart(DDP_ORG_X8);
    emr = 16'h0804;
    cmd(C_MRS, 3'h1, emr);
    odt(1'b1, 22'h003FFC);
    wr(2'h1, {$urandom(), $urandom()}, 8'hFF, 2'h1);
    rd(2'h1, 2'h2);
    emr = 16'h0004;
    cmd(C_MRS, 3'h1, emr);
    odt(1'b1, 22'h003FD5);
    // x4 strap: four data lines and one strobe pair terminated
    restart(DDP_ORG_X4);
    emr = 16'h0004;
    cmd(C_MRS, 3'h1, emr);
    odt(1'b1, 22'h0003D5);
    end_of_test();
  end
endmodule
